// >>> rtl/fdh_pkg.sv
// Package: constants and carriers for the float delay-slot hazard logic
package fdh_pkg;

   localparam int REG_W   = 3;
   localparam int DATA_W  = 32;
   localparam int NUM_REG = 8;
   localparam logic [DATA_W-1:0] REG_RST = 32'h0000_0000;

   typedef enum logic [3:0] {
      FDH_NOP,
      FDH_MUL,
      FDH_ADD,
      FDH_SUB,
      FDH_RECIP,
      FDH_MAC,
      FDH_CONV,
      FDH_MIN,
      FDH_MAX,
      FDH_CMP,
      FDH_LOAD,
      FDH_STORE,
      FDH_NEG,
      FDH_ABS,
      FDH_FLAGS
   } fdh_op_e;

   // One operation half
   typedef struct packed {
      logic                  valid;
      fdh_op_e               op;
      logic                  wr_en;
      logic [REG_W-1:0]      dst;
      logic                  rd_a_en;
      logic [REG_W-1:0]      src_a;
      logic                  rd_b_en;
      logic [REG_W-1:0]      src_b;
      logic [DATA_W-1:0]     value;
   } fdh_half_s;

   // One issued instruction, up to two parallel halves
   typedef struct packed {
      fdh_half_s first;
      fdh_half_s second;
   } fdh_instr_s;

   typedef struct packed {
      logic slot_dst_clash;
      logic slot_src_clash;
      logic par_dst_clash;
      logic slot_flags_use;
   } fdh_err_s;

   // Math and conversion ops hold one delay slot
   function automatic logic fdh_needs_slot(input fdh_op_e op);
      case (op)
         FDH_MUL, FDH_ADD, FDH_SUB, FDH_RECIP, FDH_MAC, FDH_CONV:
            fdh_needs_slot = 1'b1;
         default:
            fdh_needs_slot = 1'b0;
      endcase
   endfunction

endpackage

// >>> rtl/fdh_regfile.sv
// Eight-word float register file with two write ports and registered reads
`timescale 1ns/1ps
`default_nettype none
module fdh_regfile
   import fdh_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              we0,
   input  wire logic [REG_W-1:0]  wa0,
   input  wire logic [DATA_W-1:0] wd0,
   input  wire logic              we1,
   input  wire logic [REG_W-1:0]  wa1,
   input  wire logic [DATA_W-1:0] wd1,
   input  wire logic [REG_W-1:0]  ra,
   output logic      [DATA_W-1:0] rd
);

   typedef struct packed {
      logic [NUM_REG-1:0][DATA_W-1:0] mem;
      logic [DATA_W-1:0]              rd;
   } fdh_rf_s;

   fdh_rf_s s_q;
   fdh_rf_s s_d;

   always_comb begin
      s_d    = s_q;
      s_d.rd = s_q.mem[ra];
      if (we0) begin
         s_d.mem[wa0] = wd0;
      end
      if (we1) begin
         s_d.mem[wa1] = wd1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s_q <= '{mem: '{default: REG_RST}, rd: REG_RST};
      end else begin
         s_q <= s_d;
      end
   end

   assign rd = s_q.rd;

endmodule
`default_nettype wire

// >>> rtl/fdh_hazard.sv
// Delay-slot hazard checker and result write timing for float pipeline
`timescale 1ns/1ps
`default_nettype none
module fdh_hazard
   import fdh_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire fdh_instr_s        instr,
   input  wire logic [REG_W-1:0]  rd_addr,
   output logic      [DATA_W-1:0] rd_data,
   output fdh_err_s               err,
   output logic                   pend_busy,
   output logic [REG_W-1:0]       pend_dst
);

   // Pending two-cycle result and registered outputs
   typedef struct packed {
      logic              p_valid;
      logic [REG_W-1:0]  p_dst;
      logic [DATA_W-1:0] p_value;
      fdh_err_s          err;
   } fdh_st_s;

   fdh_st_s s_q;
   fdh_st_s s_d;

   // --------------------------------------------------------------------
   // Write ports
   // --------------------------------------------------------------------
   logic              we0;
   logic [REG_W-1:0]  wa0;
   logic [DATA_W-1:0] wd0;
   logic              we1;
   logic [REG_W-1:0]  wa1;
   logic [DATA_W-1:0] wd1;

   function automatic logic single_wr(input fdh_half_s h);
      single_wr = h.valid && h.wr_en && !fdh_needs_slot(h.op);
   endfunction

   function automatic logic slow_wr(input fdh_half_s h);
      slow_wr = h.valid && h.wr_en && fdh_needs_slot(h.op);
   endfunction

   function automatic logic reads_reg(input fdh_half_s h,
                                      input logic [REG_W-1:0] r);
      reads_reg = h.valid && ((h.rd_a_en && h.src_a == r) ||
                              (h.rd_b_en && h.src_b == r));
   endfunction

   // Halves of this issue that write in one cycle; a slow half waits
   logic [1:0]        fast;
   logic              slow_1;
   logic              slow_2;
   fdh_half_s         slow_h;
   logic              s_en;

   always_comb begin
      fast   = {single_wr(instr.second), single_wr(instr.first)};
      slow_1 = slow_wr(instr.first);
      slow_2 = slow_wr(instr.second);
      s_en   = slow_1 || slow_2;
      slow_h = slow_1 ? instr.first : instr.second;
      // Port 0: matured two-cycle result only; fast halves use port 1
      we0 = s_q.p_valid;
      wa0 = s_q.p_dst;
      wd0 = s_q.p_value;
      we1 = 1'b0;
      wa1 = '0;
      wd1 = '0;
      // First fast half, else the second, writes on port 1 this cycle, one ahead of a slow partner
      if (fast[0]) begin
         we1 = 1'b1;
         wa1 = instr.first.dst;
         wd1 = instr.first.value;
      end else if (fast[1]) begin
         we1 = 1'b1;
         wa1 = instr.second.dst;
         wd1 = instr.second.value;
      end
   end

   fdh_regfile u_rf (
      .mclk (mclk),
      .rstn (rstn),
      .we0  (we0),
      .wa0  (wa0),
      .wd0  (wd0),
      .we1  (we1),
      .wa1  (wa1),
      .wd1  (wd1),
      .ra   (rd_addr),
      .rd   (rd_data)
   );

   // --------------------------------------------------------------------
   // Hazard detection and pending slot
   // --------------------------------------------------------------------
   logic slot_hit_dst;
   logic slot_hit_src;
   logic par_clash;
   logic flag_in_slot;

   always_comb begin
      s_d = s_q;
      slot_hit_dst = s_q.p_valid &&
         ((instr.first.valid && instr.first.wr_en &&
           instr.first.dst == s_q.p_dst) ||
          (instr.second.valid && instr.second.wr_en &&
           instr.second.dst == s_q.p_dst));
      slot_hit_src = s_q.p_valid &&
         (reads_reg(instr.first, s_q.p_dst) ||
          reads_reg(instr.second, s_q.p_dst));
      par_clash = instr.first.valid && instr.second.valid &&
         instr.first.wr_en && instr.second.wr_en &&
         instr.first.dst == instr.second.dst;
      flag_in_slot = s_q.p_valid &&
         ((instr.first.valid && instr.first.op == FDH_FLAGS) ||
          (instr.second.valid && instr.second.op == FDH_FLAGS));
      s_d.err = '{slot_dst_clash: slot_hit_dst,
                  slot_src_clash: slot_hit_src,
                  par_dst_clash:  par_clash,
                  slot_flags_use: flag_in_slot};
      // One delay slot per issue with a math or conversion op; if both halves are slow, the first half's result is kept
      s_d.p_valid = s_en;
      s_d.p_dst   = s_en ? slow_h.dst : s_q.p_dst;
      s_d.p_value = s_en ? slow_h.value : s_q.p_value;
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s_q <= '{p_valid: 1'b0, p_dst: '0, p_value: REG_RST, err: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign err       = s_q.err;
   assign pend_busy = s_q.p_valid;
   assign pend_dst  = s_q.p_dst;

   // --------------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------------
   sequence s_slow_issue;
      s_en;
   endsequence

   property p_slot_result;
      @(posedge mclk) disable iff (!rstn)
         s_slow_issue |=> (we0 && wa0 == $past(slow_h.dst));
   endproperty
   a_slot_result: assert property (p_slot_result)
      else $error("two-cycle result not written one cycle after issue");

   property p_no_early;
      @(posedge mclk) disable iff (!rstn)
         (s_en && !fast[0] && !fast[1]) |-> !we1;
   endproperty
   a_no_early: assert property (p_no_early)
      else $error("two-cycle result written at issue");

   property p_move_first;
      @(posedge mclk) disable iff (!rstn)
         (s_en && fast[1] && !fast[0]) |-> we1 ##1 we0;
   endproperty
   a_move_first: assert property (p_move_first)
      else $error("move did not lead multiply by one cycle");

   property p_dst_flag;
      @(posedge mclk) disable iff (!rstn)
         slot_hit_dst |=> err.slot_dst_clash;
   endproperty
   a_dst_flag: assert property (p_dst_flag)
      else $error("slot destination clash not flagged");

   property p_src_flag;
      @(posedge mclk) disable iff (!rstn)
         (pend_busy && reads_reg(instr.first, pend_dst)) |=>
            err.slot_src_clash;
   endproperty
   a_src_flag: assert property (p_src_flag)
      else $error("slot source clash not flagged");

   property p_par_flag;
      @(posedge mclk) disable iff (!rstn)
         par_clash |=> err.par_dst_clash;
   endproperty
   a_par_flag: assert property (p_par_flag)
      else $error("parallel destination clash not flagged");

   property p_flags_flag;
      @(posedge mclk) disable iff (!rstn)
         (pend_busy && instr.first.valid && instr.first.op == FDH_FLAGS)
            |=> err.slot_flags_use;
   endproperty
   a_flags_flag: assert property (p_flags_flag)
      else $error("flag instruction in slot not flagged");

   property p_one_slot;
      @(posedge mclk) disable iff (!rstn)
         (pend_busy && !s_en) |=> !pend_busy;
   endproperty
   a_one_slot: assert property (p_one_slot)
      else $error("pending result held more than one slot");

   property p_src_second;
      @(posedge mclk) disable iff (!rstn)
         (pend_busy && reads_reg(instr.second, pend_dst)) |=>
            err.slot_src_clash;
   endproperty
   a_src_second: assert property (p_src_second)
      else $error("second half slot source clash not flagged");

   sequence s_move_issue;
      single_wr(instr.second) && !single_wr(instr.first);
   endsequence

   property p_move_write;
      @(posedge mclk) disable iff (!rstn)
         s_move_issue |-> (we1 && wa1 == instr.second.dst &&
                           wd1 == instr.second.value);
   endproperty
   a_move_write: assert property (p_move_write)
      else $error("single-cycle half not written at issue");

   property p_quiet_slot;
      @(posedge mclk) disable iff (!rstn)
         !pend_busy |=> (!err.slot_dst_clash && !err.slot_src_clash &&
                         !err.slot_flags_use);
   endproperty
   a_quiet_slot: assert property (p_quiet_slot)
      else $error("slot hazard flagged with no pending result");

endmodule
`default_nettype wire

// >>> tb/fdh_issuer.sv
// Model of the host decode stage that issues float instructions
`timescale 1ns/1ps
`default_nettype none
module fdh_issuer
   import fdh_pkg::*;
(
   input  wire logic mclk,
   output var  fdh_instr_s instr
);
   logic             allow_bad = 1'b0;
   logic             pend = 1'b0;
   logic [REG_W-1:0] pdst = '0;
   logic             bad;

   initial instr = '0;

   // ----------------------------------------------
   // Delay slot of the last issue, either half
   // ----------------------------------------------
   function automatic logic is_slow(input fdh_half_s x);
      is_slow = x.valid && x.op inside
         {FDH_MUL, FDH_ADD, FDH_SUB, FDH_RECIP, FDH_MAC, FDH_CONV};
   endfunction

   always @(posedge mclk) begin
      pend <= is_slow(instr.first) || is_slow(instr.second);
      pdst <= is_slow(instr.first) ? instr.first.dst : instr.second.dst;
   end

   function automatic logic slot_bad(input fdh_half_s x);
      slot_bad = pend && x.valid &&
         ((x.wr_en && x.dst == pdst) ||
          (x.rd_a_en && x.src_a == pdst) ||
          (x.rd_b_en && x.src_b == pdst) ||
          x.op == FDH_FLAGS);
   endfunction

   // ----------------------------------------------
   // Issue one instruction; illegal ones become idle unless allow_bad is set
   // ----------------------------------------------
   task automatic send(input fdh_half_s a, input fdh_half_s b);
      bad = slot_bad(a) || slot_bad(b) ||
         (a.valid && b.valid && a.wr_en && b.wr_en &&
          a.dst == b.dst);
      instr = (bad && !allow_bad) ? '0 : {a, b};
      @(posedge mclk);
      instr <= '0;
      #1;
   endtask
endmodule
`default_nettype wire

// >>> tb/fdh_hazard_tb.sv
// Self-checking bench for the float delay-slot hazard logic
`timescale 1ns/1ps
`default_nettype none
module fdh_hazard_tb
   import fdh_pkg::*;
;
   logic              mclk = 1'b0;
   logic              rstn = 1'b0;
   logic [REG_W-1:0]  rd_addr = '0;
   logic [DATA_W-1:0] rd_data;
   fdh_instr_s        instr;
   fdh_err_s          err;
   logic              pend_busy;
   logic [REG_W-1:0]  pend_dst;
   int                error_cnt = 0;
   int                checks_done = 0;

   initial begin
      forever #5 mclk = ~mclk;
   end

   fdh_issuer u_fdh_issuer (.mclk(mclk), .instr(instr));
   fdh_hazard u_fdh_hazard (.mclk(mclk), .rstn(rstn), .instr(instr),
      .rd_addr(rd_addr), .rd_data(rd_data), .err(err),
      .pend_busy(pend_busy), .pend_dst(pend_dst));

   // ----------------------------------------------
   // Helpers
   // ----------------------------------------------
   task automatic check(input logic [DATA_W-1:0] seen,
                        input logic [DATA_W-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic fdh_half_s h(input fdh_op_e op,
      input logic [REG_W-1:0] d, input logic [REG_W-1:0] s,
      input logic [DATA_W-1:0] v);
      h = '{1'b1, op, op != FDH_FLAGS, d, 1'b1, s, 1'b0, 3'h0, v};
   endfunction

   // Read lands at the next edge, before that edge's writes
   task automatic rdchk(input logic [REG_W-1:0] a,
                        input logic [DATA_W-1:0] exp);
      rd_addr = a;
      @(posedge mclk);
      #1;
      check(rd_data, exp);
   endtask

   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ----------------------------------------------
   // Scenarios
   // ----------------------------------------------
   task automatic t_reset;
      repeat (10) @(posedge mclk);
      #1;
      rstn = 1'b1;
      check(pend_busy, 0);
      check(err, 0);
      check(rd_data, 0);
   endtask

   task automatic t_parallel;
      u_fdh_issuer.send(h(FDH_MUL, 3'h2, 3'h1, 32'haaaa_0001),
                        h(FDH_LOAD, 3'h1, 3'h2, 32'h1111_0001));
      check(pend_busy, 1);
      check(pend_dst, 2);
      check(err, 0);
      rdchk(3'h1, 32'h1111_0001);
      check(pend_busy, 0);
      rdchk(3'h2, 32'haaaa_0001);
   endtask

   task automatic t_b2b;
      u_fdh_issuer.send(h(FDH_MUL, 3'h5, 3'h0, 32'h5555_0005), '0);
      rd_addr = 3'h5;
      u_fdh_issuer.send(h(FDH_ADD, 3'h6, 3'h0, 32'h6666_0006), '0);
      check(rd_data, 0);
      check(pend_dst, 6);
      check(err, 0);
      rdchk(3'h5, 32'h5555_0005);
      rdchk(3'h6, 32'h6666_0006);
   endtask

   task automatic t_errs;
      fdh_half_s  s[3];
      logic [3:0] e[3];
      s = '{h(FDH_LOAD, 3'h2, 3'h0, 32'h0),
            h(FDH_ADD, 3'h3, 3'h2, 32'h0),
            h(FDH_FLAGS, 3'h0, 3'h0, 32'h0)};
      e = '{4'h8, 4'h4, 4'h1};
      u_fdh_issuer.allow_bad = 1'b1;
      for (int i = 0; i < 3; i++) begin
         u_fdh_issuer.send(h(FDH_MUL, 3'h2, 3'h0, 32'h0), '0);
         u_fdh_issuer.send(s[i], '0);
         check(err, e[i]);
      end
      u_fdh_issuer.send(h(FDH_MUL, 3'h2, 3'h0, 32'h0),
                        h(FDH_LOAD, 3'h2, 3'h0, 32'h0));
      check(err, 4'h2);
      u_fdh_issuer.allow_bad = 1'b0;
      rdchk(3'h0, 32'h0);
      check(err, 0);
   endtask

   task automatic t_slots;
      for (int i = 1; i < 15; i++) begin
         u_fdh_issuer.send(h(fdh_op_e'(i), 3'(i), 3'h0, 0), '0);
         check(pend_busy, i <= 6);
      end
   endtask

   initial begin
      t_reset();
      t_parallel();
      t_b2b();
      t_errs();
      t_slots();
      tally_and_finish();
   end

   initial begin
      repeat (2000) @(posedge mclk);
      error_cnt++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
